// *** hw/sdwl_loader.v ***
`timescale 1ns/1ps
`include "sdwl_defines.vh"
module sdwl_loader (
    input wire ref_clk_i, // 125 MHz core clock
    input wire rst_n_i, // sync reset, active low
    input wire frame_n_i, // frame select pin, active low
    input wire sclk_i, // serial clock pin
    input wire sdata_i, // serial data pin
    output reg [`SDWL_CODE_BITS-1:0] analog_output_o, // converter code
    output reg [1:0] power_mode_o, // 0 normal, 1..3 power-down
    output reg powered_down_o, // high in any power-down mode
    output reg update_o, // one-cycle pulse on accepted word
    output reg abort_o // one-cycle pulse on aborted frame
);
    // states, one-hot
    // one-hot keeps each state test to a single flop
    localparam ST_IDLE = 3'h1;
    localparam ST_SHIFT = 3'h2;
    localparam ST_WAIT = 3'h4;

    // synchronised pins
    wire frame_n_s;
    wire sclk_s;
    wire sdata_s;

    // edge history and frame control
    reg sclk_d;
    reg frame_d;
    reg [2:0] state;
    reg [2:0] next_state;

    // word assembly
    reg [`SDWL_WORD_BITS-1:0] shreg;
    reg [4:0] bit_cnt;

    // decoded events, all one core cycle long, plus the word as the next fall would shift it
    wire sclk_fall;
    wire frame_rise;
    wire frame_fall;
    wire [`SDWL_WORD_BITS-1:0] word_now;
    wire word_done;
    wire frame_abort;

    // the sixteenth detected fall of an open frame closes the word;
    // its result feeds both the state machine and the output latch
    function is_last_fall;
        input [2:0] st;
        input fall;
        input [4:0] cnt;
        begin
            is_last_fall = (st == ST_SHIFT) && fall && (cnt == `SDWL_LAST_BIT);
        end
    endfunction

    // any mode other than normal switches the output stage off
    function is_power_down;
        input [1:0] mode;
        begin
            is_power_down = (mode != `SDWL_MODE_NORMAL);
        end
    endfunction

    // all three pins cross into the core domain
    // frame select resets high, its idle level, so release of reset
    // can never look like the start of a frame
    sdwl_sync2 #(.RESET_VAL(1'b1)) u_frame (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(frame_n_i),
        .sync_o(frame_n_s)
    );

    // serial clock may park high or low; only falls in a frame count
    sdwl_sync2 #(.RESET_VAL(1'b0)) u_sclk (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(sclk_i),
        .sync_o(sclk_s)
    );

    // data shares the clock's delay, keeping each bit beside its edge
    sdwl_sync2 #(.RESET_VAL(1'b0)) u_sdata (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(sdata_i),
        .sync_o(sdata_s)
    );

    // edge history of synchronised pins
    // a false clock rise after reset is harmless: only falls are used
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sclk_d <= 1'b0;
            frame_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            frame_d <= frame_n_s;
        end
    end

    // pin path timing, as seen from the core clock:
    // - every pin passes two flops; clock and frame select one more for the edge history
    // - a serial clock fall is acted on two to three core cycles late
    // - data shares that delay, so bit and edge stay aligned
    // - frame select shares it too, so a frame end never overtakes a bit
    // - each serial clock phase must last four core cycles or more
    // - sampling at 125 MHz resolves a few MHz; 30 MHz needs a faster core
    // - the trade: no second clock domain, at the cost of link speed
    // - a pin pulse shorter than one core cycle may be lost entirely
    assign sclk_fall = sclk_d & ~sclk_s & ~frame_n_s;
    assign frame_rise = ~frame_d & frame_n_s;
    assign frame_fall = frame_d & ~frame_n_s;
    assign word_now = {shreg[`SDWL_WORD_BITS-2:0], sdata_s};

    // word end and abort are exclusive: one needs frame low, one high
    assign word_done = is_last_fall(state, sclk_fall, bit_cnt);
    assign frame_abort = (state == ST_SHIFT) & frame_rise;

    // frame sequencing
    // idle: waits for frame select to fall
    // shift: counts falls; frame select rising here is an abort
    // wait: word already taken, later falls ignored until frame ends
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // a frame opens only on a seen fall of frame select
                if (frame_fall) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // frame end before the last fall discards the word
                if (frame_n_s) begin
                    next_state = ST_IDLE;
                end else if (word_done) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // extra edges after the 16th are ignored until frame ends
                if (frame_n_s) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // input shift register, msb first; cleared at frame start so a
    // word never carries bits of an aborted one
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            shreg <= 16'h0000;
        end else if (frame_fall) begin
            shreg <= 16'h0000;
        end else if (state == ST_SHIFT && sclk_fall) begin
            shreg <= word_now;
        end
    end

    // falls seen in this frame; stops at sixteen because the
    // machine leaves the shift state on the last one
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bit_cnt <= 5'h00;
        end else if (frame_fall) begin
            bit_cnt <= 5'h00;
        end else if (state == ST_SHIFT && sclk_fall) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // output latch: only a full word is ever committed, so an abort
    // or a stray edge can never leave a half-loaded code behind
    // the code still loads in power-down, so waking needs no rewrite
    // reset level is the zero code, held until the first full word
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            analog_output_o <= `SDWL_CODE_RESET;
            power_mode_o <= `SDWL_MODE_RESET;
            powered_down_o <= 1'b0;
        end else if (word_done) begin
            analog_output_o <= word_now[`SDWL_CODE_MSB:`SDWL_CODE_LSB];
            power_mode_o <= word_now[`SDWL_MODE_MSB:`SDWL_MODE_LSB];
            powered_down_o <= is_power_down(word_now[`SDWL_MODE_MSB:`SDWL_MODE_LSB]);
        end
    end

    // host-side strobes, one core cycle each
    // registered so the top outputs come straight from flops
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            update_o <= 1'b0;
            abort_o <= 1'b0;
        end else begin
            update_o <= word_done;
            abort_o <= frame_abort;
        end
    end
endmodule

// *** hw/sdwl_defines.vh ***
`ifndef SDWL_DEFINES_VH
`define SDWL_DEFINES_VH

// word layout, msb first
`define SDWL_WORD_BITS 16
`define SDWL_CODE_BITS 12
`define SDWL_MODE_MSB 13
`define SDWL_MODE_LSB 12
`define SDWL_CODE_MSB 11
`define SDWL_CODE_LSB 0
// power modes
`define SDWL_MODE_NORMAL 2'h0
`define SDWL_MODE_PD1 2'h1
`define SDWL_MODE_PD2 2'h2
`define SDWL_MODE_PD3 2'h3
// reset values
`define SDWL_CODE_RESET 12'h000
`define SDWL_MODE_RESET 2'h0
// serial clock limit
`define SDWL_SCLK_MAX_MHZ 30
`define SDWL_REF_MHZ 125
// frame timing: index of the last falling edge in a word
`define SDWL_LAST_BIT 5'h0F

`endif

// *** hw/sdwl_sync2.v ***
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module sdwl_sync2 #(
    parameter RESET_VAL = 1'b0
) (
    input wire ref_clk_i, // core clock
    input wire rst_n_i, // sync reset, active low
    input wire async_i, // pin level
    output reg sync_o // synchronised level
);
    reg meta;

    // meta is read only by sync_o
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// *** testbench/sdwl_loader_checker.sv ***
`timescale 1ns/1ps
module sdwl_loader_checker (
    input wire ref_clk_i, // core clock
    input wire rst_n_i, // sync reset, active low
    input wire frame_n_i, // frame select
    input wire sclk_i, // serial clock
    input wire sdata_i, // serial data
    input wire [11:0] analog_output_o, // converter code
    input wire [1:0] power_mode_o, // power mode
    input wire powered_down_o, // power-down flag
    input wire update_o, // accept pulse
    input wire abort_o // abort pulse
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // outputs move only on an accepted word
    AST_CODE_HOLD: assert property ($changed(analog_output_o) |-> update_o)
        else $error("code moved without update");
    AST_MODE_HOLD: assert property ($changed(power_mode_o) |-> update_o)
        else $error("mode moved without update");
    AST_PD_FLAG: assert property (powered_down_o == (power_mode_o != 2'h0))
        else $error("power-down flag mismatch");
    AST_UPD_PULSE: assert property (update_o |=> !update_o)
        else $error("update longer than one cycle");
    AST_ABT_CAUSE: assert property (abort_o |-> frame_n_i && !update_o)
        else $error("abort without frame end");
    AST_ABT_PULSE: assert property (abort_o |=> !abort_o)
        else $error("abort longer than one cycle");
    AST_UPD_FALL: assert property (update_o |-> !sclk_i)
        else $error("update not after a falling edge");
    AST_IDLE_QUIET: assert property (frame_n_i [*6] |=> !update_o)
        else $error("update with frame idle");
    // reset has to be seen here, so no disable
    AST_RESET_ZERO: assert property (disable iff (1'b0) !rst_n_i |=>
        analog_output_o == 12'h000 && power_mode_o == 2'h0) else $error("reset not zero");
    CV_PD3: cover property (update_o && power_mode_o == 2'h3);
    CV_ABORT: cover property (abort_o);
    CV_FULL: cover property (update_o && analog_output_o == 12'hFFF);
endmodule
bind sdwl_loader sdwl_loader_checker u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .frame_n_i(frame_n_i), .sclk_i(sclk_i), .sdata_i(sdata_i),
    .analog_output_o(analog_output_o), .power_mode_o(power_mode_o),
    .powered_down_o(powered_down_o), .update_o(update_o), .abort_o(abort_o));

// *** testbench/sdwl_host_model.sv ***
`timescale 1ns/1ps
module sdwl_host_model (
    output logic frame_n_o, // frame select, active low
    output logic sclk_o, // serial clock
    output logic sdata_o // serial data
);
    localparam real HALF = 62.5; // 8MHz link, far below the 30MHz ceiling
    // idle: frame high, clock parked
    initial begin
        frame_n_o = 1'b1;
        sclk_o = 1'b1;
        sdata_o = 1'b0;
    end
    // msb first; fewer than 16 bits aborts the frame, more repeats the top
    task automatic send(input logic [15:0] w, input int n);
        frame_n_o = 1'b0;
        #(HALF);
        for (int i = 15; i > 15 - n; i--) begin
            sdata_o = w[i & 15];
            #(HALF);
            sclk_o = 1'b0;
            #(HALF);
            sclk_o = 1'b1;
        end
        frame_n_o = 1'b1;
        sdata_o = ~sdata_o; // released line must not keep the last bit
        #(HALF * 4);
    endtask
    // clock pulses with the frame closed, which must shift nothing
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            sdata_o = ~sdata_o;
            #(HALF);
            sclk_o = 1'b0;
            #(HALF);
            sclk_o = 1'b1;
        end
        #(HALF * 4);
    endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    wire frame_n, sclk, sdata, pd, upd, abt;
    wire [11:0] code;
    wire [1:0] mode;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int upds = 0;
    int abts = 0;
    sdwl_host_model u_host (.frame_n_o(frame_n), .sclk_o(sclk), .sdata_o(sdata));
    sdwl_loader u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .frame_n_i(frame_n),
        .sclk_i(sclk), .sdata_i(sdata), .analog_output_o(code), .power_mode_o(mode),
        .powered_down_o(pd), .update_o(upd), .abort_o(abt));
    always #4 ref_clk_i = ~ref_clk_i;
    task automatic wrap_up;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // strobes counted so short pulses are never missed; hang guard
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (upd === 1'b1) upds <= upds + 1;
        if (abt === 1'b1) abts <= abts + 1;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic t_reset;
        check(code, 12'h000);
        check({pd, mode}, 3'h0);
    endtask
    task automatic t_abort(input int n, input logic [11:0] c, input logic [1:0] m);
        int a;
        int u;
        a = abts;
        u = upds;
        u_host.send(16'hFFFF, n);
        check(abts - a, 1);
        check(upds - u, 0);
        check(code, c);
        check(mode, m);
    endtask
    // every mode, boundary codes, unused bits set
    task automatic t_modes;
        logic [11:0] c [4] = '{12'hFFF, 12'h001, 12'h800, 12'h5A3};
        logic [1:0] m;
        int u;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i + 2);
            u = upds;
            u_host.send({2'h3, m, c[i]}, 16);
            check(code, c[i]);
            check({pd, mode}, {m != 2'h0, m});
            check(upds - u, 1);
        end
    endtask
    // falls outside a frame and past the sixteenth are refused
    task automatic t_refuse;
        int u;
        int a;
        u = upds;
        a = abts;
        u_host.idle_clocks(20);
        check(upds - u, 0);
        check(code, 12'h5A3);
        check({pd, mode}, 3'h5);
        u_host.send(16'h2C3C, 18);
        check(upds - u, 1);
        check(abts - a, 0);
        check(code, 12'hC3C);
        check({pd, mode}, 3'h6);
    endtask
    // a second reset in mid-run returns to the zero code
    task automatic t_mid_reset;
        @(posedge ref_clk_i);
        #1 rst_n_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        t_reset();
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        t_reset();
        t_abort(15, 12'h000, 2'h0);
        t_modes();
        t_abort(1, 12'h5A3, 2'h1);
        t_refuse();
        t_mid_reset();
        t_abort(2, 12'h000, 2'h0);
        wrap_up();
    end
endmodule
